// [verilog/afr_pkg.sv]
// constants for the amplifier fault report and output arrangement block
// assumes a single 100 MHz clock and a byte-wide register bank
package afr_pkg;
  localparam int unsigned CLOCK_MHZ = 100;
  localparam logic [6:0] ADDR_FAULT_CONTROL = 7'h2D;   // decimal 45
  localparam logic [6:0] ADDR_FAULT_LOG     = 7'h6D;   // decimal 109
  localparam logic [6:0] ADDR_FAULT_LIVE    = 7'h7C;   // decimal 124
  localparam logic [6:0] ADDR_RO_FIRST      = 7'h60;   // decimal 96
  localparam int unsigned CLEAR_BIT_POS     = 2;
  localparam logic [7:0] CONTROL_RESET      = 8'h00;
  localparam logic [7:0] LOG_RESET          = 8'h00;
  localparam int unsigned FAULT_WIDTH       = 8;
  // fault vector bit positions
  localparam int unsigned BIT_DC_OFFSET   = 7;
  localparam int unsigned BIT_PIN_SHORT   = 6;
  localparam int unsigned BIT_OVERTEMP    = 5;
  localparam int unsigned BIT_TEMP_WARN   = 4;
  localparam int unsigned BIT_UNDERVOLT   = 3;
  localparam int unsigned BIT_PLL         = 2;
  localparam int unsigned BIT_OVERCURRENT = 1;
  localparam int unsigned BIT_AUX_FAULT   = 0;
  // output arrangements, one-hot
  typedef enum logic [3:0] {
    AFR_PARALLEL_BRIDGED_MONO = 4'h1,
    AFR_SE2_PLUS_BRIDGED      = 4'h2,
    AFR_BRIDGED_DIFFERENTIAL2 = 4'h4,
    AFR_SINGLE_ENDED_OUTPUT4  = 4'h8
  } afr_arrangement_type;
endpackage

// [verilog/afr_sticky_bit.sv]
// one sticky fault bit: sets on the source, clears on request
// assumes synchronous inputs; the set wins over a clear in the same cycle
`timescale 1ns/1ps
module afr_sticky_bit (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  // control
  input  wire logic i_source,
  input  wire logic i_clear,
  // state
  output logic      o_sticky
);
  logic next_sticky;

  always_comb begin
    next_sticky = o_sticky;
    if (i_clear) begin
      next_sticky = 1'b0;
    end
    if (i_source) begin
      next_sticky = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_sticky <= 1'b0;
    end else begin
      o_sticky <= next_sticky;
    end
  end
endmodule // afr_sticky_bit

// [verilog/afr_fault_supervisor.sv]
// fault report, register bank subset and output arrangement decode
// assumes the serial decoder presents byte reads/writes as one-cycle strobes
// and that all pins are synchronous to the master clock
//
// Overview of operation
// - alert pin pulls low one clock after any fault source becomes active
// - alert pin is open drain: only driven low, external pull-up
// - live fault register at 124 shows sources unlatched
// - sticky log at 109 sets on a fault and holds until cleared
// - setting then clearing bit 2 of register 45 empties the sticky log, except bits of faults still live
// - both fault registers share one bit order, dc offset at bit 7
// - two strap pins select one of four output arrangements
// - bridged arrangement pairs two half bridges into one differential channel
// - parallel bridged drives both bridged pairs with the same mono signal
// - addresses 96 to 127 are read-only; writes are ignored
`timescale 1ns/1ps
module afr_fault_supervisor (
  // clock and reset (active-low enable pin doubles as reset)
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // protection sources
  input  wire logic [7:0]  i_fault_sources,
  // strap pins
  input  wire logic        i_arrangement_strap_a,
  input  wire logic        i_arrangement_strap_b,
  // mute pin, active low
  input  wire logic        i_mute_n,
  // register port from the serial decoder
  input  wire logic [6:0]  i_reg_addr,
  input  wire logic        i_reg_write,
  input  wire logic        i_reg_read,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_reg_rvalid,
  // alert pin, open drain
  output logic             o_fault_alert_out,
  output logic             o_fault_alert_oe,
  // output arrangement
  output logic      [3:0]  o_arrangement,
  output logic      [1:0]  o_bridged_pairs,
  output logic      [3:0]  o_single_ended_stages,
  output logic             o_parallel_bridged_mono,
  output logic             o_stage_run
);
  logic [7:0] live;
  logic [7:0] next_live;
  logic [7:0] control;
  logic [7:0] next_control;
  logic [7:0] sticky;
  logic       clear_pulse;
  logic [7:0] next_rdata;
  logic       next_rvalid;
  afr_pkg::afr_arrangement_type arr;
  afr_pkg::afr_arrangement_type next_arr;

  // live copy; sources are already in bit order
  always_comb begin
    next_live = i_fault_sources;
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      live <= 8'h00;
    end else begin
      live <= next_live;
    end
  end

  // control register; clear fires on the falling edge of the clear bit
  always_comb begin
    next_control = control;
    if (i_reg_write && i_reg_addr == afr_pkg::ADDR_FAULT_CONTROL) begin
      next_control = i_reg_wdata;
    end
  end

  assign clear_pulse = control[afr_pkg::CLEAR_BIT_POS] && !next_control[afr_pkg::CLEAR_BIT_POS];

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      control <= afr_pkg::CONTROL_RESET;
    end else begin
      control <= next_control;
    end
  end

  genvar g;
  generate
    for (g = 0; g < afr_pkg::FAULT_WIDTH; g++) begin : g_sticky
      afr_sticky_bit u_bit (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_source  (live[g]),
        .i_clear   (clear_pulse),
        .o_sticky  (sticky[g])
      );
    end
  endgenerate

  // open drain alert: drive low only while a fault is live
  assign o_fault_alert_out = 1'b0;
  assign o_fault_alert_oe  = |live;

  // register reads; writes to the read-only range never reach state
  always_comb begin
    next_rdata  = 8'h00;
    next_rvalid = i_reg_read;
    if (i_reg_read) begin
      unique case (i_reg_addr)
        afr_pkg::ADDR_FAULT_CONTROL: next_rdata = control;
        afr_pkg::ADDR_FAULT_LOG:     next_rdata = sticky;
        afr_pkg::ADDR_FAULT_LIVE:    next_rdata = live;
        default:                     next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rdata  <= next_rdata;
      o_reg_rvalid <= next_rvalid;
    end
  end

  // strap decode (a, b)
  always_comb begin
    unique case ({i_arrangement_strap_a, i_arrangement_strap_b})
      2'b00:   next_arr = afr_pkg::AFR_PARALLEL_BRIDGED_MONO;
      2'b01:   next_arr = afr_pkg::AFR_SE2_PLUS_BRIDGED;
      2'b10:   next_arr = afr_pkg::AFR_BRIDGED_DIFFERENTIAL2;
      default: next_arr = afr_pkg::AFR_SINGLE_ENDED_OUTPUT4;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      arr <= afr_pkg::AFR_SINGLE_ENDED_OUTPUT4;
    end else begin
      arr <= next_arr;
    end
  end

  // stage pairing: bit n of bridged pairs joins half bridges 2n and 2n+1
  always_comb begin
    o_arrangement           = arr;
    o_bridged_pairs         = 2'h0;
    o_single_ended_stages   = 4'h0;
    o_parallel_bridged_mono = 1'b0;
    unique case (arr)
      afr_pkg::AFR_PARALLEL_BRIDGED_MONO: begin
        o_bridged_pairs         = 2'h3;
        o_parallel_bridged_mono = 1'b1;
      end
      afr_pkg::AFR_SE2_PLUS_BRIDGED: begin
        o_bridged_pairs       = 2'h2;
        o_single_ended_stages = 4'h3;
      end
      afr_pkg::AFR_BRIDGED_DIFFERENTIAL2: begin
        o_bridged_pairs = 2'h3;
      end
      afr_pkg::AFR_SINGLE_ENDED_OUTPUT4: begin
        o_single_ended_stages = 4'hF;
      end
    endcase
  end

  // stage runs only when enabled (out of reset) and unmuted
  assign o_stage_run = i_reset_n && i_mute_n;

  // live and strap decode antecedents carry i_reset_n so the edge that releases reset starts no check on reset state
  a_alert_follows_live: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (o_fault_alert_oe == (live != 8'h00))) else $error("alert does not follow live faults");
  a_alert_pull_only: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (o_fault_alert_out == 1'b0)) else $error("alert driven high");
  a_live_tracks_src: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_reset_n |=> (live == $past(i_fault_sources))) else $error("live register lags");
  a_sticky_sets_src: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (live[5]) |=> sticky[5]) else $error("sticky bit missed a fault");
  a_sticky_holds: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (sticky[7] && !clear_pulse) |=> sticky[7]) else $error("sticky bit lost");
  a_clear_empties: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (clear_pulse && live == 8'h00) |=> (sticky == 8'h00)) else $error("clear failed");
  a_log_live_order: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (live[7] && !clear_pulse) |=> sticky[7]) else $error("bit order mismatch");
  a_strap_decode: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_reset_n && {i_arrangement_strap_a, i_arrangement_strap_b} == 2'b10) |=>
    (arr == afr_pkg::AFR_BRIDGED_DIFFERENTIAL2)) else $error("strap decode wrong");
  a_mono_both_pairs: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    o_parallel_bridged_mono |-> (o_bridged_pairs == 2'h3)) else $error("mono lacks both pairs");
  a_ro_write_ignored: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_reg_write && i_reg_addr >= afr_pkg::ADDR_RO_FIRST) |=> $stable(control)) else $error("ro write took");
  a_new_after_clear: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (clear_pulse && live[1]) |=> sticky[1]) else $error("fault lost at clear");
  a_read_live_data: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_reg_read && i_reg_addr == afr_pkg::ADDR_FAULT_LIVE) |=> (o_reg_rdata == $past(live)))
    else $error("live read wrong");
  a_read_log_data: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_reg_read && i_reg_addr == afr_pkg::ADDR_FAULT_LOG) |=> (o_reg_rdata == $past(sticky)))
    else $error("log read wrong");
  a_rvalid_pulse: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_reg_read |=> o_reg_rvalid) else $error("read not answered");
  a_rvalid_single: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !i_reg_read |=> !o_reg_rvalid) else $error("answer without read");
  a_sticky_no_spur: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (!live[0] && !sticky[0]) |=> !sticky[0]) else $error("sticky bit set without fault");
  a_log_write_ignored: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_reg_write && i_reg_addr == afr_pkg::ADDR_FAULT_LOG && !clear_pulse) |=>
    (sticky == ($past(sticky) | $past(live)))) else $error("log write took");
  a_strap_mono_decode: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_reset_n && {i_arrangement_strap_a, i_arrangement_strap_b} == 2'b00) |=>
    (arr == afr_pkg::AFR_PARALLEL_BRIDGED_MONO)) else $error("mono strap decode wrong");
  a_strap_se_decode: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_reset_n && {i_arrangement_strap_a, i_arrangement_strap_b} == 2'b11) |=>
    (arr == afr_pkg::AFR_SINGLE_ENDED_OUTPUT4)) else $error("single ended strap decode wrong");
  a_bridged_pairs: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (arr == afr_pkg::AFR_BRIDGED_DIFFERENTIAL2) |-> (o_bridged_pairs == 2'h3 && o_single_ended_stages == 4'h0))
    else $error("bridged pairing wrong");
endmodule // afr_fault_supervisor

// [sim/afr_host_model.sv]
// model of the system controller: control pins and register strobes
// assumes the bench calls one task at a time; pins change at the rising edge
`timescale 1ns/1ps
module afr_host_model (
  // clock and answers
  input  wire logic       i_clock,
  input  wire logic [7:0] i_reg_rdata,
  input  wire logic       i_reg_rvalid,
  // control pins
  output logic            o_reset_n,
  output logic            o_mute_n,
  output logic            o_strap_a,
  output logic            o_strap_b,
  // register port
  output logic [6:0]      o_reg_addr,
  output logic            o_reg_write,
  output logic            o_reg_read,
  output logic [7:0]      o_reg_wdata
);
  initial begin
    o_reset_n   = 1'b0;
    o_mute_n    = 1'b0;
    o_strap_a   = 1'b0;
    o_strap_b   = 1'b0;
    o_reg_addr  = 7'h00;
    o_reg_write = 1'b0;
    o_reg_read  = 1'b0;
    o_reg_wdata = 8'h00;
  end
  // straps settle while disabled and muted; the clock already runs
  task automatic power_up(input logic a, input logic b);
    @(posedge i_clock);
    o_strap_a <= a;
    o_strap_b <= b;
    o_mute_n  <= 1'b0;
    repeat (3) @(posedge i_clock);
    o_reset_n <= 1'b1;
    @(posedge i_clock);
  endtask
  task automatic unmute();
    @(posedge i_clock);
    o_mute_n <= 1'b1;
  endtask
  task automatic power_down();
    @(posedge i_clock);
    o_mute_n <= 1'b0;
    @(posedge i_clock);
    o_reset_n <= 1'b0;
  endtask
  // released lines show the inverse of the last value
  task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_reg_addr  <= a;
    o_reg_wdata <= d;
    o_reg_write <= 1'b1;
    @(posedge i_clock);
    o_reg_write <= 1'b0;
    o_reg_addr  <= ~a;
    o_reg_wdata <= ~d;
  endtask
  task automatic reg_read(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(posedge i_clock);
    o_reg_addr <= a;
    o_reg_read <= 1'b1;
    @(posedge i_clock);
    o_reg_read <= 1'b0;
    o_reg_addr <= ~a;
    #1;
    d = i_reg_rdata;
    v = i_reg_rvalid;
  endtask
endmodule // afr_host_model

// [sim/afr_fault_supervisor_tb_top.sv]
// bench for the fault supervisor: straps, fault registers, alert pin
// assumes the host model drives every control and register input
`timescale 1ns/1ps
module afr_fault_supervisor_tb_top;
  logic i_clock = 1'b0;
  logic rst_n, mute_n, sa, sb, wr, rd, rv, a_out, a_oe, mono, run;
  logic [6:0] addr;
  logic [7:0] wd, rdat, src = 8'h00, got;
  logic [3:0] arr, se;
  logic [1:0] pairs;
  logic v;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  int exp_log = 0;
  logic [1:0] t_pairs [4] = '{2'h3, 2'h2, 2'h3, 2'h0};
  logic [3:0] t_se [4] = '{4'h0, 4'h3, 4'h0, 4'hF};
  always #5 i_clock = ~i_clock;
  afr_host_model i_afr_host_model (.i_clock(i_clock), .i_reg_rdata(rdat), .i_reg_rvalid(rv),
    .o_reset_n(rst_n), .o_mute_n(mute_n), .o_strap_a(sa), .o_strap_b(sb), .o_reg_addr(addr),
    .o_reg_write(wr), .o_reg_read(rd), .o_reg_wdata(wd));
  afr_fault_supervisor i_afr_fault_supervisor (.i_clock(i_clock), .i_reset_n(rst_n),
    .i_fault_sources(src), .i_arrangement_strap_a(sa), .i_arrangement_strap_b(sb),
    .i_mute_n(mute_n), .i_reg_addr(addr), .i_reg_write(wr), .i_reg_read(rd), .i_reg_wdata(wd),
    .o_reg_rdata(rdat), .o_reg_rvalid(rv), .o_fault_alert_out(a_out), .o_fault_alert_oe(a_oe),
    .o_arrangement(arr), .o_bridged_pairs(pairs), .o_single_ended_stages(se),
    .o_parallel_bridged_mono(mono), .o_stage_run(run));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic rd_chk(input string name, input logic [6:0] a, input logic [7:0] exp);
    i_afr_host_model.reg_read(a, got, v);
    chk({name, "_valid"}, {7'h00, v}, 8'h01);
    chk(name, got, exp);
  endtask
  task automatic set_src(input logic [7:0] s);
    @(posedge i_clock);
    src <= s;
    exp_log = exp_log | s;
    repeat (2) @(posedge i_clock);
    #1;
    chk("alert_oe", {7'h00, a_oe}, {7'h00, |s});
    chk("alert_out", {7'h00, a_out}, 8'h00);
    rd_chk("live", 7'h7C, s);
    rd_chk("log", 7'h6D, exp_log[7:0]);
  endtask
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'hFACB));
    for (int k = 0; k < 4; k++) begin
      i_afr_host_model.power_up(k[1], k[0]);
      #1;
      chk("arrangement", {4'h0, arr}, 8'h01 << k);
      chk("pairs", {6'h00, pairs}, {6'h00, t_pairs[k]});
      chk("se_stages", {4'h0, se}, {4'h0, t_se[k]});
      chk("mono", {7'h00, mono}, {7'h00, k == 0});
      chk("run_muted", {7'h00, run}, 8'h00);
      rd_chk("ctrl_reset", 7'h2D, 8'h00);
      i_afr_host_model.unmute();
      #1;
      chk("run", {7'h00, run}, 8'h01);
      i_afr_host_model.power_down();
      #1;
      chk("run_down", {7'h00, run}, 8'h00);
    end
    i_afr_host_model.power_up(1'b1, 1'b0);
    exp_log = 0;
    for (int k = 0; k < 16; k++) set_src(k < 8 ? 8'h01 << k : 8'($urandom));
    set_src(8'h22);
    i_afr_host_model.reg_write(7'h2D, 8'h00);
    rd_chk("log_no_clear", 7'h6D, exp_log[7:0]);
    i_afr_host_model.reg_write(7'h2D, 8'h04);
    rd_chk("ctrl", 7'h2D, 8'h04);
    rd_chk("log_held", 7'h6D, exp_log[7:0]);
    i_afr_host_model.reg_write(7'h2D, 8'h00);
    exp_log = 8'h22;
    rd_chk("log_cleared", 7'h6D, 8'h22);
    set_src(8'h01);
    foreach (t_se[k]) i_afr_host_model.reg_write(7'h60 + 7'(k * 9), 8'($urandom));
    i_afr_host_model.reg_write(7'h6D, 8'h00);
    i_afr_host_model.reg_write(7'h7C, 8'hFF);
    rd_chk("log_ro", 7'h6D, exp_log[7:0]);
    rd_chk("live_ro", 7'h7C, 8'h01);
    rd_chk("unmapped", 7'h50, 8'h00);
    set_src(8'h00);
    i_afr_host_model.reg_write(7'h2D, 8'h04);
    i_afr_host_model.reg_write(7'h2D, 8'h00);
    exp_log = 0;
    rd_chk("log_empty", 7'h6D, 8'h00);
    end_of_test();
  end
endmodule // afr_fault_supervisor_tb_top
